// File: src/plow_regs.vh
// constants for the keypad function sequencer: offsets, fields, resets, timing
`ifndef PLOW_REGS_VH
`define PLOW_REGS_VH

// register byte offsets
`define CTRL_OFF         12'h000
`define STATUS_OFF       12'h004
`define KEYS_OFF         12'h008

// control fields and reset value
`define CTRL_LOCK_BIT    0
`define CTRL_COAST_BIT   1
`define CTRL_RST         2'h2

// status fields
`define ST_ON_BIT        0
`define ST_VEE_BIT       1
`define ST_FLOAT_BIT     2
`define ST_COAST_BIT     3
`define ST_PWR_BIT       4
`define ST_FN_LSB        5
`define ST_FN_MSB        11

// key positions in the key vector
`define KEY_ONOFF        0
`define KEY_MODE         1
`define KEY_RAISE        2
`define KEY_LOWER        3
`define KEY_LEFT         4
`define KEY_RIGHT        5
`define NUM_KEYS         6

// timing, in its own unit
`define CLK_KHZ          36'd10000
`define RAISE_TO_MS      36'd2500
`define OTHER_TO_MS      36'd4250
`define FLOAT_HOLD_MS    36'd750
`define QUICK_PRESS_MS   36'd2000
`define COAST_MS         36'd200
`define DEBOUNCE_MS      36'd10
`define IDLE_MIN         36'd20
`define MS_PER_MIN       36'd60000

`endif

// File: src/key_debounce.v
// two-flop synchroniser and hold-time debouncer for one key
`timescale 1ns/100ps

module key_debounce #(
	parameter [35:0] DEB_CYC = 36'd100000
) (
	// system
	input  wire clk,
	input  wire rst_n,
	// key
	input  wire raw,
	output reg  clean_q
);

	reg        sync1_q;
	reg        sync2_q;
	reg [16:0] cnt_q;

	always @(posedge clk) begin
		if (!rst_n) begin
			sync1_q <= 1'h0;
			sync2_q <= 1'h0;
			cnt_q   <= 17'h0;
			clean_q <= 1'h0;
		end else begin
			sync1_q <= raw;
			sync2_q <= sync1_q;
			// level must stand for the full debounce time before it is accepted
			if (sync2_q == clean_q) begin
				cnt_q <= 17'h0;
			end else if ({19'h0, cnt_q} >= DEB_CYC - 36'h1) begin
				cnt_q   <= 17'h0;
				clean_q <= sync2_q;
			end else begin
				cnt_q <= cnt_q + 17'h1;
			end
		end
	end

endmodule // key_debounce

// File: src/plow_keypad_function_sequencer.v
// keypad function sequencer: keys to valve commands, mode, float, time-outs, apb registers
`timescale 1ns/100ps
`include "plow_regs.vh"

module plow_keypad_function_sequencer #(
	parameter [35:0] RAISE_CYC = `RAISE_TO_MS * `CLK_KHZ,
	parameter [35:0] OTHER_CYC = `OTHER_TO_MS * `CLK_KHZ,
	parameter [35:0] FLOAT_CYC = `FLOAT_HOLD_MS * `CLK_KHZ,
	parameter [35:0] QUICK_CYC = `QUICK_PRESS_MS * `CLK_KHZ,
	parameter [35:0] COAST_CYC = `COAST_MS * `CLK_KHZ,
	parameter [35:0] DEB_CYC   = `DEBOUNCE_MS * `CLK_KHZ,
	parameter [35:0] IDLE_CYC  = `IDLE_MIN * `MS_PER_MIN * `CLK_KHZ
) (
	// system
	input  wire        clk,
	input  wire        rst_n,
	// keypad, high while pressed
	input  wire        onoff_key,
	input  wire        mode_key,
	input  wire        raise_key,
	input  wire        lower_key,
	input  wire        left_scoop_key,
	input  wire        right_vee_key,
	// vehicle status
	input  wire        ignition_on,
	input  wire        plow_connected,
	// valve driver commands
	output reg         motor_on,
	output reg         raise_valve,
	output reg         lower_valve,
	output reg         float_valve,
	output reg         angle_left_valve,
	output reg         angle_right_valve,
	output reg         scoop_valve,
	output reg         vee_valve,
	// indicator lights
	output reg         power_indicator,
	output reg         mode_indicator,
	output reg         float_indicator,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr
);

	localparam [6:0] F_NONE  = 7'h01;
	localparam [6:0] F_RAISE = 7'h02;
	localparam [6:0] F_LOWER = 7'h04;
	localparam [6:0] F_LEFT  = 7'h08;
	localparam [6:0] F_RIGHT = 7'h10;
	localparam [6:0] F_SCOOP = 7'h20;
	localparam [6:0] F_VEE   = 7'h40;

	wire [5:0]  raw_keys;
	wire [5:0]  key_db;
	reg  [5:0]  key_prev_q;
	wire [5:0]  key_rise;
	wire [5:0]  key_fall;
	wire        powered;
	wire        any_press;
	wire        coasting;

	reg         on_q;
	reg         vee_q;
	reg         float_q;
	reg  [6:0]  fn_q;
	reg  [25:0] fn_cnt_q;
	reg  [24:0] mode_cnt_q;
	reg  [35:0] idle_cnt_q;
	reg  [20:0] coast_cnt_q;
	reg  [6:0]  coast_fn_q;
	reg  [1:0]  ctrl_q;

	reg  [6:0]  fn_d;
	reg  [25:0] fn_cnt_d;
	reg         float_d;
	reg  [20:0] coast_cnt_d;
	reg  [6:0]  coast_fn_d;
	reg         fn_end;
	reg         fn_held;
	reg  [35:0] fn_limit;
	reg  [6:0]  fn_start;
	reg  [6:0]  drive;

	assign raw_keys = {right_vee_key, left_scoop_key, lower_key, raise_key, mode_key, onoff_key};

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_KEYS; gi = gi + 1) begin : g_key
			key_debounce #(
				.DEB_CYC (DEB_CYC)
			) u_deb (
				.clk     (clk),
				.rst_n   (rst_n),
				.raw     (raw_keys[gi]),
				.clean_q (key_db[gi])
			);
		end
	endgenerate

	assign key_rise  = key_db & ~key_prev_q;
	assign key_fall  = ~key_db & key_prev_q;
	assign powered   = on_q & ignition_on & plow_connected;
	assign any_press = |key_rise;
	assign coasting  = coast_cnt_q != 21'h0;

	// which key holds the running function, and its limit
	always @* begin
		fn_held  = 1'h0;
		fn_limit = OTHER_CYC;
		case (fn_q)
			F_RAISE: begin
				fn_held  = key_db[`KEY_RAISE];
				fn_limit = RAISE_CYC;
			end
			F_LOWER: begin
				fn_held = key_db[`KEY_LOWER];
			end
			F_LEFT, F_SCOOP: begin
				fn_held = key_db[`KEY_LEFT];
			end
			F_RIGHT, F_VEE: begin
				fn_held = key_db[`KEY_RIGHT];
			end
			default: begin
				fn_held = 1'h0;
			end
		endcase
	end

	// new function from a fresh press; lock bit blocks the function keys
	always @* begin
		fn_start = F_NONE;
		if (!ctrl_q[`CTRL_LOCK_BIT]) begin
			if (key_rise[`KEY_RAISE]) begin
				fn_start = F_RAISE;
			end else if (key_rise[`KEY_LOWER]) begin
				fn_start = F_LOWER;
			end else if (key_rise[`KEY_LEFT]) begin
				fn_start = vee_q ? F_SCOOP : F_LEFT;
			end else if (key_rise[`KEY_RIGHT]) begin
				fn_start = vee_q ? F_VEE : F_RIGHT;
			end
		end
	end

	// function sequencer
	always @* begin
		fn_d        = fn_q;
		fn_cnt_d    = fn_cnt_q + 26'h1;
		float_d     = float_q;
		coast_cnt_d = coasting ? coast_cnt_q - 21'h1 : 21'h0;
		coast_fn_d  = coasting ? coast_fn_q : F_NONE;
		fn_end      = 1'h0;
		if (!powered) begin
			// emergency stop: no coast, every valve shut
			fn_d        = F_NONE;
			float_d     = 1'h0;
			coast_cnt_d = 21'h0;
			coast_fn_d  = F_NONE;
		end else if (fn_q == F_NONE) begin
			if (fn_start != F_NONE) begin
				// a new press cuts any coast short, keeping one function
				fn_d        = fn_start;
				fn_cnt_d    = 26'h0;
				coast_cnt_d = 21'h0;
				coast_fn_d  = F_NONE;
				if (fn_start == F_RAISE) begin
					float_d = 1'h0;
				end
			end
		end else if (fn_q == F_LOWER) begin
			if (!fn_held) begin
				fn_end = 1'h1;
			end else if ({10'h0, fn_cnt_q} >= FLOAT_CYC - 36'h1) begin
				// float valve takes over; lower itself never times out
				fn_d    = F_NONE;
				float_d = 1'h1;
			end
		end else if (!fn_held || {10'h0, fn_cnt_q} >= fn_limit - 36'h1) begin
			// key stays held after a time-out, but only a fresh edge restarts
			fn_end = 1'h1;
		end
		if (fn_end) begin
			fn_d = F_NONE;
			if (ctrl_q[`CTRL_COAST_BIT]) begin
				coast_cnt_d = COAST_CYC[20:0];
				coast_fn_d  = fn_q;
			end
		end
	end

	// valve drive: running function, else coasting one, else float
	always @* begin
		drive = F_NONE;
		if (fn_q != F_NONE) begin
			drive = fn_q;
		end else if (coasting) begin
			drive = coast_fn_q;
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			key_prev_q  <= 6'h0;
			on_q        <= 1'h0;
			vee_q       <= 1'h0;
			float_q     <= 1'h0;
			fn_q        <= F_NONE;
			fn_cnt_q    <= 26'h0;
			coast_cnt_q <= 21'h0;
			coast_fn_q  <= F_NONE;
			mode_cnt_q  <= 25'h0;
			idle_cnt_q  <= 36'h0;
		end else begin
			key_prev_q  <= key_db;
			fn_q        <= fn_d;
			fn_cnt_q    <= fn_cnt_d;
			float_q     <= float_d;
			coast_cnt_q <= coast_cnt_d;
			coast_fn_q  <= coast_fn_d;
			if (key_rise[`KEY_ONOFF]) begin
				on_q <= ~on_q;
			end else if (on_q && idle_cnt_q >= IDLE_CYC - 36'h1) begin
				on_q <= 1'h0;
			end
			if (!on_q || any_press) begin
				idle_cnt_q <= 36'h0;
			end else begin
				idle_cnt_q <= idle_cnt_q + 36'h1;
			end
			// long holds leave the wing mode as it is, so only quick ones toggle
			if (!key_db[`KEY_MODE]) begin
				mode_cnt_q <= 25'h0;
			end else if ({11'h0, mode_cnt_q} < QUICK_CYC) begin
				mode_cnt_q <= mode_cnt_q + 25'h1;
			end
			if (!on_q) begin
				vee_q <= 1'h0;
			end else if (powered && key_fall[`KEY_MODE] && {11'h0, mode_cnt_q} < QUICK_CYC) begin
				vee_q <= ~vee_q;
			end
		end
	end

	// registered outputs
	always @(posedge clk) begin
		if (!rst_n) begin
			motor_on          <= 1'h0;
			raise_valve       <= 1'h0;
			lower_valve       <= 1'h0;
			float_valve       <= 1'h0;
			angle_left_valve  <= 1'h0;
			angle_right_valve <= 1'h0;
			scoop_valve       <= 1'h0;
			vee_valve         <= 1'h0;
			power_indicator   <= 1'h0;
			mode_indicator    <= 1'h0;
			float_indicator   <= 1'h0;
		end else begin
			// pump runs only for a live powered function; coast has it off
			motor_on          <= (fn_q != F_NONE) && (fn_q != F_LOWER);
			raise_valve       <= drive == F_RAISE;
			lower_valve       <= drive == F_LOWER;
			float_valve       <= float_q && drive == F_NONE;
			angle_left_valve  <= drive == F_LEFT;
			angle_right_valve <= drive == F_RIGHT;
			scoop_valve       <= drive == F_SCOOP;
			vee_valve         <= drive == F_VEE;
			power_indicator   <= powered;
			mode_indicator    <= on_q & vee_q;
			float_indicator   <= float_q;
		end
	end

	// apb slave: zero wait states, read data loaded in the setup cycle
	wire apb_setup;
	wire apb_write;
	reg  [31:0] rd_d;
	reg         err_d;

	assign pready    = 1'h1;
	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pwrite;

	always @* begin
		rd_d  = 32'h0;
		err_d = 1'h0;
		if (paddr == `CTRL_OFF) begin
			rd_d[1:0] = ctrl_q;
		end else if (paddr == `STATUS_OFF) begin
			rd_d[`ST_ON_BIT]              = on_q;
			rd_d[`ST_VEE_BIT]             = vee_q;
			rd_d[`ST_FLOAT_BIT]           = float_q;
			rd_d[`ST_COAST_BIT]           = coasting;
			rd_d[`ST_PWR_BIT]             = powered;
			rd_d[`ST_FN_MSB:`ST_FN_LSB]   = fn_q;
		end else if (paddr == `KEYS_OFF) begin
			rd_d[5:0] = key_db;
		end else begin
			err_d = 1'h1;
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q  <= `CTRL_RST;
			prdata  <= 32'h0;
			pslverr <= 1'h0;
		end else begin
			if (apb_setup) begin
				prdata  <= pwrite ? 32'h0 : rd_d;
				pslverr <= err_d;
			end
			if (apb_write && paddr == `CTRL_OFF) begin
				ctrl_q <= pwdata[1:0];
			end
		end
	end

endmodule // plow_keypad_function_sequencer

// File: bench/plow_seq_chk_sva.sv
// assertions on the keypad sequencer valve and light outputs
`timescale 1ns/100ps
module plow_seq_chk #(
	parameter [35:0] RAISE_CYC = 36'd50,
	parameter [35:0] OTHER_CYC = 36'd80,
	parameter [35:0] DEB_CYC   = 36'd4,
	parameter [35:0] IDLE_CYC  = 36'd300
) (
	// system
	input wire clk,
	input wire rst_n,
	// keys and vehicle
	input wire onoff_key,
	input wire mode_key,
	input wire raise_key,
	input wire lower_key,
	input wire left_scoop_key,
	input wire right_vee_key,
	input wire ignition_on,
	input wire plow_connected,
	// outputs
	input wire motor_on,
	input wire raise_valve,
	input wire lower_valve,
	input wire float_valve,
	input wire angle_left_valve,
	input wire angle_right_valve,
	input wire scoop_valve,
	input wire vee_valve,
	input wire power_indicator,
	input wire float_indicator
);
	wire [6:0]  v = {raise_valve, lower_valve, float_valve, angle_left_valve, angle_right_valve, scoop_valve, vee_valve};
	wire [5:0]  k = {onoff_key, mode_key, raise_key, lower_key, left_scoop_key, right_vee_key};
	reg  [35:0] run_q;
	reg  [35:0] idle_q;
	reg  [5:0]  k_q;
	// raw key changes reset the idle count; debounce lag is in the margin
	always @(posedge clk) begin
		k_q <= k;
		run_q <= motor_on ? run_q + 36'd1 : 36'd0;
		idle_q <= (k != k_q) ? 36'd0 : idle_q + 36'd1;
		if (!rst_n) begin
			run_q <= 36'd0;
			idle_q <= 36'd0;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_one; $onehot0(v); endproperty
	a_one: assert property (p_one) else $error("two valves on");
	property p_pwr; power_indicator |-> $past(ignition_on && plow_connected); endproperty
	a_pwr: assert property (p_pwr) else $error("power light without vehicle");
	property p_rto; raise_valve && motor_on |-> run_q < RAISE_CYC + 36'd2; endproperty
	a_rto: assert property (p_rto) else $error("raise too long");
	property p_oto; (v[3:0] != 4'h0) && motor_on |-> run_q < OTHER_CYC + 36'd2; endproperty
	a_oto: assert property (p_oto) else $error("wing too long");
	property p_stop; $fell(power_indicator) && $past(ignition_on && plow_connected) |=> v == 7'h00 && !motor_on;
	endproperty
	a_stop: assert property (p_stop) else $error("off left valve on");
	property p_idle; power_indicator |-> idle_q < IDLE_CYC + DEB_CYC + 36'd10; endproperty
	a_idle: assert property (p_idle) else $error("no idle shutdown");
	property p_flt; float_valve |-> float_indicator; endproperty
	a_flt: assert property (p_flt) else $error("float valve without light");
	property p_rclr; $rose(raise_valve) |-> ##[0:2] !float_indicator; endproperty
	a_rclr: assert property (p_rclr) else $error("raise kept float");
	c_flt: cover property ($rose(float_indicator));
	c_scoop: cover property (scoop_valve && motor_on);
	c_rto: cover property ($fell(motor_on) && raise_valve);
endmodule // plow_seq_chk
bind plow_keypad_function_sequencer plow_seq_chk #(.RAISE_CYC(RAISE_CYC), .OTHER_CYC(OTHER_CYC), .DEB_CYC(DEB_CYC),
	.IDLE_CYC(IDLE_CYC)) u_chk (.*);

// File: bench/keypad_model.sv
// keypad model: presses with a contact bounce on every make
`timescale 1ns/100ps
module keypad_model (
	// system
	input  wire       clk,
	// presses wanted
	input  wire [5:0] press,
	// contacts
	output wire [5:0] keys
);
	reg [5:0] p1_q;
	reg [5:0] p2_q;
	always @(posedge clk) begin
		p1_q <= press;
		p2_q <= p1_q;
	end
	// opens once, one cycle after first closing
	assign keys = press & ~(p1_q & ~p2_q);
endmodule // keypad_model

// File: bench/testbench.sv
// self-checking bench for the keypad function sequencer
`timescale 1ns/100ps
`include "plow_regs.vh"
module testbench;
	reg         clk;
	reg         rst_n;
	reg  [5:0]  press;
	wire [5:0]  keys;
	reg         ign;
	reg         plow;
	reg         psel;
	reg         penable;
	reg         pwrite;
	reg  [11:0] paddr;
	reg  [31:0] pwdata;
	wire [31:0] prdata;
	wire        pready;
	wire        pslverr;
	wire [6:0]  vlv;
	wire        motor;
	wire        pwr;
	wire        mode_ind;
	wire        flt;
	reg  [31:0] rd;
	integer     failures;
	integer     n_compared;
	integer     i;
	keypad_model pad (.clk(clk), .press(press), .keys(keys));
	// shortened timing; quick-press limit stays real, bench mode presses are far shorter
	localparam [35:0] T_RAISE = 36'd50;
	localparam [35:0] T_OTHER = 36'd80;
	localparam [35:0] T_FLOAT = 36'd20;
	localparam [35:0] T_COAST = 36'd5;
	localparam [35:0] T_DEB   = 36'd4;
	localparam [35:0] T_IDLE  = 36'd300;
	plow_keypad_function_sequencer #(.RAISE_CYC(T_RAISE), .OTHER_CYC(T_OTHER), .FLOAT_CYC(T_FLOAT),
		.COAST_CYC(T_COAST), .DEB_CYC(T_DEB), .IDLE_CYC(T_IDLE)) dut (.clk(clk), .rst_n(rst_n),
		.onoff_key(keys[0]), .mode_key(keys[1]),
		.raise_key(keys[2]), .lower_key(keys[3]), .left_scoop_key(keys[4]), .right_vee_key(keys[5]),
		.ignition_on(ign), .plow_connected(plow), .motor_on(motor), .raise_valve(vlv[6]), .lower_valve(vlv[5]),
		.float_valve(vlv[4]), .angle_left_valve(vlv[3]), .angle_right_valve(vlv[2]), .scoop_valve(vlv[1]),
		.vee_valve(vlv[0]), .power_indicator(pwr), .mode_indicator(mode_ind), .float_indicator(flt),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("BAD %0t seen %h want %h", $time, seen, exp);
			end
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task push(input integer k, input integer n);
		begin
			press[k] <= 1'b1;
			cyc(n);
			press[k] <= 1'b0;
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			@(posedge clk);
			while (pready !== 1'b1) @(posedge clk);
			rd = pslverr ? 32'hffffffff : prdata;
			psel <= 1'b0;
			penable <= 1'b0;
			// idle edge so a following call never reassigns psel in the same step
			@(posedge clk);
		end
	endtask
	task end_sim;
		begin
			$display("compared %0d mismatches %0d", n_compared, failures);
			if (failures == 0 && n_compared > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#(100 * 4000);
		failures = failures + 1;
		end_sim;
	end
	initial begin
		failures = 0;
		n_compared = 0;
		{rst_n, press, psel, penable, pwrite, paddr, pwdata} = 0;
		ign = 1'b1;
		plow = 1'b1;
		cyc(5);
		rst_n <= 1'b1;
		cyc(2);
		chk({pwr, vlv}, 8'h00);
		apb(1'b0, `CTRL_OFF, 0);
		chk(rd, `CTRL_RST);
		apb(1'b0, 12'h00c, 0);
		chk(rd, 32'hffffffff);
		push(`KEY_ONOFF, 10);
		cyc(5);
		chk({pwr, mode_ind}, 2'b10);
		// lock bit must hold off a function key press
		apb(1'b1, `CTRL_OFF, 32'h3);
		apb(1'b0, `CTRL_OFF, 0);
		chk(rd, 32'h3);
		push(`KEY_RAISE, 15);
		chk({motor, vlv}, 8'h00);
		apb(1'b1, `CTRL_OFF, `CTRL_RST);
		apb(1'b0, `STATUS_OFF, 0);
		chk(rd, (32'h1 << `ST_ON_BIT) | (32'h1 << `ST_PWR_BIT) | (32'h1 << `ST_FN_LSB));
		ign <= 1'b0;
		cyc(3);
		chk(pwr, 1'b0);
		ign <= 1'b1;
		plow <= 1'b0;
		cyc(3);
		chk(pwr, 1'b0);
		plow <= 1'b1;
		press[`KEY_RAISE] <= 1'b1;
		cyc(15);
		chk({motor, vlv}, 8'hc0);
		cyc(60);
		chk(vlv, 7'h00);
		press[`KEY_RAISE] <= 1'b0;
		cyc(15);
		push(`KEY_RAISE, 15);
		chk(vlv, 7'h40);
		cyc(10);
		chk({motor, vlv}, 8'h40);
		cyc(10);
		push(`KEY_LOWER, 14);
		chk(vlv, 7'h20);
		cyc(20);
		chk({flt, vlv}, 8'h00);
		press[`KEY_LOWER] <= 1'b1;
		cyc(45);
		chk({flt, vlv[4]}, 2'b11);
		press[`KEY_LOWER] <= 1'b0;
		cyc(15);
		push(`KEY_RAISE, 15);
		chk(flt, 1'b0);
		cyc(20);
		for (i = 0; i < 2; i = i + 1) begin
			chk(mode_ind, i);
			push(`KEY_LEFT, 15);
			chk(vlv, i ? 7'h02 : 7'h08);
			cyc(20);
			push(`KEY_RIGHT, 15);
			chk(vlv, i ? 7'h01 : 7'h04);
			cyc(20);
			push(`KEY_MODE, 10);
			cyc(15);
		end
		chk(mode_ind, 1'b0);
		press[`KEY_LEFT] <= 1'b1;
		cyc(105);
		chk(vlv, 7'h00);
		press[`KEY_LEFT] <= 1'b0;
		cyc(15);
		press[`KEY_LEFT] <= 1'b1;
		cyc(12);
		chk(vlv, 7'h08);
		push(`KEY_ONOFF, 12);
		cyc(3);
		chk({pwr, vlv}, 8'h00);
		press[`KEY_LEFT] <= 1'b0;
		cyc(5);
		push(`KEY_ONOFF, 10);
		cyc(270);
		chk(pwr, 1'b1);
		cyc(60);
		chk(pwr, 1'b0);
		end_sim;
	end
endmodule // testbench
